//--- hdl/fsp_defs.svh
/*
 * Constants of the flash sector protection block: register offsets, field
 * positions, sector and group counts and timing counts.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH
// What this block does
// - Program and erase blocked per sector or group by protection state.
// - Asserted write-protect blocks sectors 0, 1, 268 and 269.
// - Hardware write protection acts in persistent and password modes.
// - With no mode bit set, persistent protection mode applies.
// - Two one-time mode bits; the persistent one fixes persistent mode.
// - Password bit fixes the device to password protection forever.
// - Once either mode bit is set, the other can never be set.
// - Delivered state: all sectors unprotected, no persistent bit set.
// - Sector is persistently locked, dynamically locked, or unlocked.
// - One persistent bit per group of at most four sectors.
// - Each small boot sector has its own persistent bit.
// - Persistent bits are set individually by a write command.
// - Persistent bit erase clears all bits at once, never one.
// - Global freeze bit at 1 holds persistent bits; 0 allows change.
// - In persistent mode the freeze bit clears at power-up and reset.
// - No command clears the freeze bit in persistent mode.
// - Volatile dynamic bit per sector, cleared at reset, freely written.
// - Sector protected when group persistent bit OR dynamic bit is set.
// - Protected target unchanged; busy about 1 us program, 50 us erase.
// - In password mode the freeze bit comes up set after reset.

// Register offsets (word offsets on the plain port)
`define FSP_OFS_CTRL 4'h0
`define FSP_OFS_STAT 4'h1
`define FSP_OFS_MODE 4'h2
`define FSP_OFS_DYN 4'h3
`define FSP_OFS_PPB 4'h4
`define FSP_OFS_REQ 4'h5
`define FSP_OFS_RESULT 4'h6
`define FSP_OFS_PWOK 4'h7

// CTRL command field (bits 2:0) and write-data fields
`define FSP_CMD_PPB_SET 3'h1
`define FSP_CMD_PPB_ERASE 3'h2
`define FSP_CMD_FREEZE 3'h3
`define FSP_CMD_DYN_SET 3'h4
`define FSP_CMD_DYN_CLR 3'h5
`define FSP_CMD_SEL_PERS 3'h6
`define FSP_CMD_SEL_PASS 3'h7
`define FSP_BIT_OP_ERASE 22
`define FSP_BIT_OP_GO 23

// Sizes
`define FSP_SECTORS 270
`define FSP_GROUPS 80
`define FSP_LAST_SECTOR 9'h10d
`define FSP_PREV_SECTOR 9'h10c

// Busy times on a protected target, in ns, and cycles at 40 ns
`define FSP_CLK_NS 40
`define FSP_PROG_NS 1000
`define FSP_ERASE_NS 50000
`define FSP_PROG_CYC ((`FSP_PROG_NS) / (`FSP_CLK_NS))
`define FSP_ERASE_CYC ((`FSP_ERASE_NS) / (`FSP_CLK_NS))
`endif

//--- hdl/fsp_map_if.sv
/*
 * Interface carrying an address to the sector/group decoder and its answer.
 * Assumes both ends run from the same clock; the decode is combinational.
 */
`timescale 1ns/1ns
interface fsp_map_if;
  logic [21:11] addr;
  fsp_pkg::fsp_sector_t sector;
  fsp_pkg::fsp_group_t group;
  modport user (output addr, input sector, group);
  modport map (input addr, output sector, group);
endinterface : fsp_map_if

//--- hdl/fsp_pkg.sv
/*
 * Types of the flash sector protection block.
 * Assumes the constants header is available to the files that use these.
 */
package fsp_pkg;
  typedef enum logic [2:0] {
    FSP_IDLE = 3'b001,
    FSP_BUSY = 3'b010,
    FSP_DONE = 3'b100
  } fsp_state_e;
  typedef logic [8:0] fsp_sector_t;
  typedef logic [6:0] fsp_group_t;
endpackage : fsp_pkg

//--- hdl/fsp_protect.sv
/*
 * Sector protection logic: persistent bits per group, dynamic bits per
 * sector, global freeze bit, mode selection bits, write-protect guard and
 * a checker of program/erase requests with the refused-operation busy time.
 * Assumes synchronous inputs and a register master that never waits.
 * Non-volatile bits are modelled as flops loaded on power-up reset only.
 */
`timescale 1ns/1ns
`include "fsp_defs.svh"
module fsp_protect (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic por_n,
  input wire logic clk_en,
  input wire logic wp_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic op_allow,
  output logic op_busy,
  output logic freeze_out
);
  // Non-volatile bits survive hardware reset, cleared only by por_n
  logic [`FSP_GROUPS-1:0] ppb_r;
  logic sel_pers_r;
  logic sel_pass_r;
  logic [`FSP_SECTORS-1:0] dyn_r;
  logic freeze_r;
  logic rst_seen_r;
  logic pw_ok_r;
  fsp_pkg::fsp_state_e st_r;
  logic [10:0] cnt_r;
  logic allow_r;
  logic refused_r;
  logic last_ok_r;
  logic busy_r;
  logic [10:0] busy_run_r;
  logic [21:11] req_addr_r;
  logic [31:0] rdata_r;

  fsp_map_if cmd_m ();
  fsp_map_if req_m ();
  fsp_sector_map u_cmd_map (.m(cmd_m.map));
  fsp_sector_map u_req_map (.m(req_m.map));
  assign cmd_m.addr = reg_wdata[21:11];
  assign req_m.addr = req_addr_r;

  // Write decode
  wire wr_ctrl = reg_wr && (reg_addr == `FSP_OFS_CTRL);
  wire wr_req = reg_wr && (reg_addr == `FSP_OFS_REQ);
  wire wr_pw = reg_wr && (reg_addr == `FSP_OFS_PWOK);
  wire [2:0] cmd = reg_wdata[2:0];
  wire pass_mode = sel_pass_r;
  wire c_ppb_set = wr_ctrl && cmd == `FSP_CMD_PPB_SET && !freeze_r;
  wire c_ppb_erase = wr_ctrl && cmd == `FSP_CMD_PPB_ERASE && !freeze_r;
  wire c_freeze = wr_ctrl && cmd == `FSP_CMD_FREEZE;
  wire c_dyn_set = wr_ctrl && cmd == `FSP_CMD_DYN_SET;
  wire c_dyn_clr = wr_ctrl && cmd == `FSP_CMD_DYN_CLR;
  // Either mode bit blocks the other for good
  wire c_sel_pers = wr_ctrl && cmd == `FSP_CMD_SEL_PERS &&
    !sel_pass_r;
  wire c_sel_pass = wr_ctrl && cmd == `FSP_CMD_SEL_PASS &&
    !sel_pers_r;
  // Password match is decided outside; only honoured in password mode
  wire c_unfreeze = wr_pw && reg_wdata[0] && pass_mode;

  // Request decode: sector protected by group bit OR dynamic bit
  wire [8:0] rs = req_m.sector;
  wire [6:0] rg = req_m.group;
  wire sec_prot = ppb_r[rg] | dyn_r[rs];
  wire wp_hit = !wp_n && (rs == 9'h000 || rs == 9'h001 ||
    rs == `FSP_PREV_SECTOR || rs == `FSP_LAST_SECTOR);
  wire blocked = sec_prot | wp_hit;
  wire req_go = wr_req && reg_wdata[`FSP_BIT_OP_GO];
  wire req_erase = reg_wdata[`FSP_BIT_OP_ERASE];
  wire [10:0] busy_len = req_erase ? 11'(`FSP_ERASE_CYC) :
                                     11'(`FSP_PROG_CYC);

  // Non-volatile bits: shipped clear, one-time mode bits
  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n) begin
      ppb_r <= '0;
      sel_pers_r <= 1'b0;
      sel_pass_r <= 1'b0;
    end else if (clk_en) begin
      if (c_ppb_erase) begin
        ppb_r <= '0;
      end else if (c_ppb_set) begin
        ppb_r[cmd_m.group] <= 1'b1;
      end
      if (c_sel_pers) begin
        sel_pers_r <= 1'b1;
      end
      if (c_sel_pass) begin
        sel_pass_r <= 1'b1;
      end
    end
  end

  // Dynamic bits are volatile and cleared by resetn, not by por_n
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dyn_r <= '0;
    end else if (clk_en) begin
      if (c_dyn_set) begin
        dyn_r[cmd_m.sector] <= 1'b1;
      end else if (c_dyn_clr) begin
        dyn_r[cmd_m.sector] <= 1'b0;
      end
    end
  end

  // Freeze resets clear; a flag one edge after release reloads it set in
  // password mode, since the mode bit may not be sampled under reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      freeze_r <= 1'b0;
      rst_seen_r <= 1'b0;
    end else if (clk_en) begin
      rst_seen_r <= 1'b1;
      if (!rst_seen_r) begin
        freeze_r <= pass_mode;
      end else if (c_freeze) begin
        freeze_r <= 1'b1;
      end else if (c_unfreeze) begin
        freeze_r <= 1'b0;
      end
    end
  end

  // Request checker: refused targets stay busy for the polling time
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= fsp_pkg::FSP_IDLE;
      cnt_r <= 11'h000;
      allow_r <= 1'b0;
      refused_r <= 1'b0;
      last_ok_r <= 1'b0;
      busy_r <= 1'b0;
      req_addr_r <= '0;
      pw_ok_r <= 1'b0;
    end else if (clk_en) begin
      pw_ok_r <= c_unfreeze;
      case (st_r)
        fsp_pkg::FSP_IDLE: begin
          allow_r <= 1'b0;
          busy_r <= 1'b0;
          if (req_go) begin
            req_addr_r <= reg_wdata[21:11];
            cnt_r <= busy_len;
            st_r <= fsp_pkg::FSP_DONE;
          end
        end
        fsp_pkg::FSP_DONE: begin
          refused_r <= blocked;
          last_ok_r <= !blocked;
          busy_r <= blocked;
          allow_r <= !blocked;
          st_r <= blocked ? fsp_pkg::FSP_BUSY : fsp_pkg::FSP_IDLE;
        end
        fsp_pkg::FSP_BUSY: begin
          allow_r <= 1'b0;
          cnt_r <= cnt_r - 11'h001;
          if (cnt_r == 11'h001) begin
            busy_r <= 1'b0;
            st_r <= fsp_pkg::FSP_IDLE;
          end
        end
        default: st_r <= fsp_pkg::FSP_IDLE;
      endcase
    end
  end

  // Read mux; RESULT holds the last verdict since op_allow is only a pulse
  wire [31:0] stat_w = {26'h0, pw_ok_r, refused_r, sel_pass_r, sel_pers_r,
                        busy_r, freeze_r};
  wire [31:0] rd_sel =
    (reg_addr == `FSP_OFS_STAT) ? stat_w :
    (reg_addr == `FSP_OFS_MODE) ? {30'h0, sel_pass_r, sel_pers_r} :
    (reg_addr == `FSP_OFS_DYN) ? {31'h0, dyn_r[cmd_m.sector]} :
    (reg_addr == `FSP_OFS_PPB) ? {31'h0, ppb_r[cmd_m.group]} :
    (reg_addr == `FSP_OFS_RESULT) ? {30'h0, refused_r, last_ok_r} :
    32'h0000_0000;

  // Read data stand one cycle after the strobe and only there
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 32'h0000_0000;
    end else if (clk_en) begin
      rdata_r <= reg_rd ? rd_sel : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_r;
  assign op_allow = allow_r;
  assign op_busy = busy_r;
  assign freeze_out = freeze_r;

  // Length of the running refusal window; helper for the polling check
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busy_run_r <= 11'h000;
    end else if (clk_en) begin
      busy_run_r <= busy_r ? busy_run_r + 11'h001 : 11'h000;
    end
  end

  // Modes are exclusive
  property p_mode_excl;
    @(posedge ref_clk) disable iff (!por_n) !(sel_pers_r && sel_pass_r);
  endproperty
  a_mode_excl: assert property (p_mode_excl)
    else $error("both modes");

  // Mode bit, once set, stays set
  property p_pass_sticky;
    @(posedge ref_clk) disable iff (!por_n) sel_pass_r |=> sel_pass_r;
  endproperty
  a_pass_sticky: assert property (p_pass_sticky)
    else $error("mode dropped");

  // Frozen persistent bits do not change
  property p_frozen;
    @(posedge ref_clk) disable iff (!resetn) freeze_r |=> $stable(ppb_r);
  endproperty
  a_frozen: assert property (p_frozen) else $error("ppb moved");

  // Freeze never falls in persistent mode
  property p_no_unfreeze;
    @(posedge ref_clk) disable iff (!resetn)
      (freeze_r && !sel_pass_r) |=> freeze_r;
  endproperty
  a_no_unfreeze: assert property (p_no_unfreeze)
    else $error("freeze cleared");

  // Write-protected target never allowed
  property p_wp;
    @(posedge ref_clk) disable iff (!resetn)
      (st_r == fsp_pkg::FSP_DONE && clk_en && wp_hit) |=> !allow_r;
  endproperty
  a_wp: assert property (p_wp) else $error("wp sector allowed");

  // Protected target leads to a busy period, not an allow
  sequence s_refuse;
    st_r == fsp_pkg::FSP_DONE && clk_en && sec_prot;
  endsequence
  property p_refuse;
    @(posedge ref_clk) disable iff (!resetn)
      s_refuse |=> (op_busy && !allow_r);
  endproperty
  a_refuse: assert property (p_refuse) else $error("no refusal");

  // Program refusal ends within 41 cycles of the request, a margin over its polling time
  property p_prog_time;
    @(posedge ref_clk) disable iff (!resetn)
      (req_go && !req_erase && st_r == fsp_pkg::FSP_IDLE && clk_en)
        |=> ##[1:40] !op_busy;
  endproperty
  a_prog_time: assert property (p_prog_time)
    else $error("program busy too long");

  // Erase clears every persistent bit
  property p_erase;
    @(posedge ref_clk) disable iff (!por_n)
      (c_ppb_erase && clk_en) |=> (ppb_r == '0);
  endproperty
  a_erase: assert property (p_erase) else $error("erase partial");

  // Persistent mode bit, once set, stays set
  property p_pers_sticky;
    @(posedge ref_clk) disable iff (!por_n) sel_pers_r |=> sel_pers_r;
  endproperty
  a_pers_sticky: assert property (p_pers_sticky)
    else $error("mode dropped");

  // The allow verdict stands for one cycle only
  property p_allow_pulse;
    @(posedge ref_clk) disable iff (!resetn)
      (allow_r && clk_en) |=> !allow_r;
  endproperty
  a_allow_pulse: assert property (p_allow_pulse)
    else $error("allow held");

  // Each decided request leaves exactly one verdict bit set
  property p_verdict;
    @(posedge ref_clk) disable iff (!resetn)
      (st_r == fsp_pkg::FSP_DONE && clk_en) |=> (refused_r != last_ok_r);
  endproperty
  a_verdict: assert property (p_verdict)
    else $error("verdict split");

  // First edge after reset in password mode comes up frozen
  sequence s_boot_pass;
    !rst_seen_r && clk_en && sel_pass_r;
  endsequence
  property p_freeze_pass;
    @(posedge ref_clk) disable iff (!resetn) s_boot_pass |=> freeze_r;
  endproperty
  a_freeze_pass: assert property (p_freeze_pass)
    else $error("freeze not set");

  // First edge after reset in persistent mode stays unfrozen
  sequence s_boot_pers;
    !rst_seen_r && clk_en && !sel_pass_r;
  endsequence
  property p_freeze_pers;
    @(posedge ref_clk) disable iff (!resetn) s_boot_pers |=> !freeze_r;
  endproperty
  a_freeze_pers: assert property (p_freeze_pers)
    else $error("freeze not clear");

  // No refusal window outlasts the erase polling time
  property p_busy_len;
    @(posedge ref_clk) disable iff (!resetn)
      busy_run_r <= 11'(`FSP_ERASE_CYC);
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy too long");
endmodule : fsp_protect

//--- hdl/fsp_sector_map.sv
/*
 * Address to sector index and protection group decoder.
 * Assumes address bits 21..11; sectors below 8 and above 261 are 8 KB
 * boot sectors, the rest 64 KB sectors in groups of at most four.
 */
`timescale 1ns/1ns
module fsp_sector_map (
  fsp_map_if.map m
);
  wire [5:0] hi = m.addr[21:16];
  wire [2:0] lo = m.addr[13:11];
  wire [1:0] mid = m.addr[15:14];
  wire bot = (hi == 6'h00);
  wire top = (hi == 6'h3f);
  // Big sectors: 64 KB each, indexed from the 21..14 bits
  wire [8:0] big = {1'b0, m.addr[21:14]} + 9'h007;
  // Boot region decode; the 64 KB remainders of each end form odd groups
  assign m.sector = (bot && mid == 2'h0) ? {6'h00, lo} :
                    (top && mid == 2'h3) ? (9'h106 + {6'h00, lo}) :
                    big;
  assign m.group = (bot && mid == 2'h0) ? {4'h0, lo} :
                   bot ? 7'h08 :
                   (top && mid == 2'h3) ? (7'h48 + {4'h0, lo}) :
                   top ? 7'h47 :
                   (7'h08 + {1'b0, hi});
endmodule : fsp_sector_map

//--- sim/fsp_host_model.sv
/* Host processor model driving the register port of the protection block.
   Assumes a free-running ref_clk; every change lands just after an edge. */
`timescale 1ns/1ns
module fsp_host_model (
  input wire logic ref_clk,
  output logic [3:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  // Idle bus from time zero
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One-cycle write; data inverted afterwards so stale values never match
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr

  // One-cycle read; data stands only in the following cycle
  task automatic rd(input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_wdata <= ~d;
    #1;
    q = reg_rdata;
  endtask : rd

  // Preprogram every persistent bit, then erase them all at once
  task automatic erase_all();
    for (int i = 0; i < 2048; i++) begin
      wr(4'h0, {10'h0, i[10:0], 8'h0, 3'h1});
    end
    wr(4'h0, 32'h2);
  endtask : erase_all
endmodule : fsp_host_model

//--- sim/fsp_protect_bench.sv
/* Self-checking bench of the sector protection block.
   Assumes the host model above and a 25 MHz clock. */
`timescale 1ns/1ns
module fsp_protect_bench;
  typedef struct {logic [10:0] a; logic wp; logic er; logic ok;} fsp_row_s;
  logic ref_clk = 1'b0;
  logic resetn, por_n, clk_en, wp_n, reg_wr, reg_rd;
  logic op_allow, op_busy, freeze_out;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  int err_total = 0;
  int checked = 0;
  // Boot sectors, a persistent group and a dynamic sector, with and without wp
  fsp_row_s rows[10] = '{'{11'h000, 0, 0, 0}, '{11'h001, 0, 1, 0},
    '{11'h7fe, 0, 0, 0}, '{11'h7ff, 0, 0, 0}, '{11'h7fd, 0, 0, 1},
    '{11'h000, 1, 0, 1}, '{11'h020, 1, 0, 0}, '{11'h03f, 1, 1, 0},
    '{11'h040, 1, 0, 0}, '{11'h060, 1, 0, 1}};

  // 40 ns period
  always #20 ref_clk = ~ref_clk;

  fsp_protect dut_u (.ref_clk(ref_clk), .resetn(resetn), .por_n(por_n),
    .clk_en(clk_en), .wp_n(wp_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .op_allow(op_allow), .op_busy(op_busy),
    .freeze_out(freeze_out));

  fsp_host_model host_u (.ref_clk(ref_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  function automatic logic [31:0] cw(input logic [10:0] a,
                                     input logic [2:0] c);
    cw = {10'h0, a, 8'h0, c};
  endfunction : cw

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic report_and_stop();
    if (err_total == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // Request, wait for the verdict, time any refusal window
  task automatic req(input logic [10:0] a, input logic er, input logic ok);
    int n;
    logic [31:0] q;
    host_u.wr(4'h5, {8'h0, 1'b1, er, a, 11'h0});
    n = 0;
    while (op_allow !== 1'b1 && op_busy !== 1'b1 && n < 6) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("op_allow", {31'h0, ok}, {31'h0, op_allow});
    n = 0;
    while (op_busy === 1'b1 && n < 2000) begin
      n++;
      @(posedge ref_clk);
      #1;
    end
    chk("busy_cycles", ok ? 0 : (er ? 1250 : 25), n);
    host_u.rd(4'h6, 32'h0, q);
    chk("result", {30'h0, ~ok, ok}, q);
  endtask : req

  // Reset pulse; a power-up reset also reloads the non-volatile bits
  task automatic pulse_reset(input logic pwr);
    resetn <= 1'b0;
    por_n <= ~pwr;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    por_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : pulse_reset

  // Watchdog sized well above the expected run
  initial begin
    #(40 * 60000);
    err_total++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    resetn = 1'b0;
    por_n = 1'b0;
    clk_en = 1'b1;
    wp_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    por_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    host_u.rd(4'h1, 32'h0, d);
    chk("stat_reset", 32'h0, d);
    host_u.rd(4'h4, cw(11'h020, 3'h0), d);
    chk("ppb_delivered", 32'h0, d);
    host_u.wr(4'h0, cw(11'h020, 3'h1));
    host_u.wr(4'h0, cw(11'h040, 3'h4));
    host_u.rd(4'h4, cw(11'h03f, 3'h0), d);
    chk("ppb_group", 32'h1, d);
    host_u.rd(4'h4, cw(11'h040, 3'h0), d);
    chk("ppb_next", 32'h0, d);
    for (int i = 0; i < 10; i++) begin
      wp_n <= rows[i].wp;
      req(rows[i].a, rows[i].er, rows[i].ok);
    end
    wp_n <= 1'b1;
    host_u.wr(4'h0, cw(11'h040, 3'h5));
    req(11'h040, 1'b0, 1'b1);
    clk_en <= 1'b0;
    host_u.wr(4'h0, cw(11'h060, 3'h4));
    clk_en <= 1'b1;
    host_u.rd(4'h3, cw(11'h060, 3'h0), d);
    chk("dyn_clk_en_low", 32'h0, d);
    host_u.wr(4'h0, cw(11'h060, 3'h4));
    host_u.wr(4'h0, cw(11'h000, 3'h3));
    host_u.wr(4'h0, cw(11'h060, 3'h1));
    host_u.wr(4'h7, 32'h1);
    host_u.rd(4'h4, cw(11'h060, 3'h0), d);
    chk("ppb_frozen", 32'h0, d);
    chk("freeze_kept", 32'h1, freeze_out);
    pulse_reset(1'b0);
    chk("freeze_hw_reset", 32'h0, freeze_out);
    host_u.rd(4'h3, cw(11'h060, 3'h0), d);
    chk("dyn_reset", 32'h0, d);
    host_u.rd(4'h4, cw(11'h020, 3'h0), d);
    chk("ppb_kept", 32'h1, d);
    host_u.erase_all();
    host_u.rd(4'h4, cw(11'h020, 3'h0), d);
    chk("ppb_erased", 32'h0, d);
    host_u.rd(4'h4, cw(11'h7ff, 3'h0), d);
    chk("ppb_erased_top", 32'h0, d);
    host_u.wr(4'h0, 32'h7);
    host_u.wr(4'h0, 32'h6);
    host_u.rd(4'h1, 32'h0, d);
    chk("sel_password", 32'h2, {30'h0, d[3:2]});
    pulse_reset(1'b0);
    chk("freeze_password", 32'h1, freeze_out);
    host_u.wr(4'h7, 32'h1);
    host_u.rd(4'h1, 32'h0, d);
    chk("freeze_unlock", 32'h0, freeze_out);
    chk("stat_unlock", 32'h0, {31'h0, d[0]});
    wp_n <= 1'b0;
    req(11'h7ff, 1'b0, 1'b0);
    wp_n <= 1'b1;
    pulse_reset(1'b1);
    host_u.wr(4'h0, 32'h6);
    host_u.wr(4'h0, 32'h7);
    host_u.rd(4'h1, 32'h0, d);
    chk("sel_persistent", 32'h1, {30'h0, d[3:2]});
    host_u.rd(4'h2, 32'h0, d);
    chk("mode_reg", 32'h1, d);
    report_and_stop();
  end
endmodule : fsp_protect_bench
